// ### rtl/pfr_regs.sv
// Retained power-fail comparator and regulator switching configuration,
// reached over an Avalon-MM slave with one wait state per access.
// Assumes a single master that holds each request until waitrequest is low
// and a supply mode level arriving on an asynchronous pin.
//
// Register access over Avalon-MM is this design's own decision.
`include "pfr_cfg.svh"
module pfr_regs
   import pfr_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [11:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic [1:0] o_avs_response,
   output logic o_avs_waitrequest,
   input wire logic i_high_volt_mode,
   output logic o_pof_enable,
   output logic [3:0] o_pof_threshold,
   output logic o_pof_high_table,
   output logic o_pof_thr_valid,
   output logic o_main_sw_en,
   output logic o_radio_sw_en,
   output logic o_high_sw_en
);

   pfr_regs_s q;
   pfr_regs_s d;
   logic mode_s;
   logic thr_rsvd;
   logic req;
   logic ack;
   pfr_sel_e sel;

   // Address decode, shared by the read path, the write path and checks
   function automatic pfr_sel_e dec(input logic [11:0] a);
      pfr_sel_e s;
      s = PFR_SEL_NONE;
      unique case (a)
         `PFR_OFS_POF_CFG: s = PFR_SEL_POF;
         `PFR_OFS_MAIN_SW: s = PFR_SEL_MAIN;
         `PFR_OFS_RADIO_SW: s = PFR_SEL_RADIO;
         `PFR_OFS_HIGH_SW: s = PFR_SEL_HIGH;
         `PFR_OFS_STATUS: s = PFR_SEL_STAT;
         default: s = PFR_SEL_NONE;
      endcase
      return s;
   endfunction : dec

   // Readback image of the power-fail configuration word
   function automatic logic [31:0] pof_word(input logic en,
                                            input pfr_thr_t mt,
                                            input pfr_thr_t ht);
      logic [31:0] w;
      w = '0;
      w[`PFR_POF_EN_BIT] = en;
      w[`PFR_MAIN_THR_MSB:`PFR_MAIN_THR_LSB] = mt;
      w[`PFR_HIGH_THR_MSB:`PFR_HIGH_THR_LSB] = ht;
      return w;
   endfunction : pof_word

   pfr_sync u_mode_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_level(i_high_volt_mode),
      .o_level(mode_s)
   );

   pfr_thr_sel u_thr_sel (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_high_mode(mode_s),
      .i_pof_en(q.pof_en),
      .i_main_thr(q.main_thr),
      .i_high_thr(q.high_thr),
      .o_thr(o_pof_threshold),
      .o_high_tab(o_pof_high_table),
      .o_valid(o_pof_thr_valid),
      .o_rsvd(thr_rsvd)
   );

   assign req = i_avs_read || i_avs_write;
   assign ack = req && (q.bus == PFR_ACK);
   assign sel = dec(i_avs_address);

   always_comb begin
      logic [31:0] rd;
      rd = '0;
      d = q;
      unique case (q.bus)
         PFR_IDLE: begin
            if (req) begin
               d.bus = PFR_ACK;
               d.resp = (sel == PFR_SEL_NONE) ? `PFR_RESP_DECERR
                                              : `PFR_RESP_OK;
               unique case (sel)
                  PFR_SEL_POF: begin
                     rd = pof_word(q.pof_en, q.main_thr, q.high_thr); // RL4
                  end
                  PFR_SEL_MAIN: begin
                     rd[`PFR_SW_EN_BIT] = q.main_sw;
                  end
                  PFR_SEL_RADIO: begin
                     rd[`PFR_SW_EN_BIT] = q.radio_sw;
                  end
                  PFR_SEL_HIGH: begin
                     rd[`PFR_SW_EN_BIT] = q.high_sw;
                  end
                  PFR_SEL_STAT: begin
                     rd[`PFR_ST_MODE_BIT] = mode_s;
                     rd[`PFR_ST_RSVD_BIT] = thr_rsvd;
                     rd[`PFR_ST_THR_MSB:`PFR_ST_THR_LSB] = o_pof_threshold;
                  end
                  PFR_SEL_NONE: begin
                     rd = '0;
                  end
               endcase
               d.rdata = i_avs_read ? rd : '0;
            end
         end
         PFR_ACK: begin
            d.bus = PFR_IDLE;
            if (i_avs_write) begin
               unique case (sel)
                  PFR_SEL_POF: begin
                     if (i_avs_byteenable[0]) begin
                        d.pof_en = i_avs_writedata[`PFR_POF_EN_BIT]; // RL1
                        // Reserved low codes are kept as written
                        d.main_thr = i_avs_writedata[`PFR_MAIN_THR_MSB:
                                                     `PFR_MAIN_THR_LSB]; // RL2
                     end
                     if (i_avs_byteenable[1]) begin
                        d.high_thr = i_avs_writedata[`PFR_HIGH_THR_MSB:
                                                     `PFR_HIGH_THR_LSB]; // RL3
                     end
                  end
                  PFR_SEL_MAIN: begin
                     if (i_avs_byteenable[0]) begin
                        d.main_sw = i_avs_writedata[`PFR_SW_EN_BIT]; // RL5
                     end
                  end
                  PFR_SEL_RADIO: begin
                     if (i_avs_byteenable[0]) begin
                        d.radio_sw = i_avs_writedata[`PFR_SW_EN_BIT]; // RL5
                     end
                  end
                  PFR_SEL_HIGH: begin
                     if (i_avs_byteenable[0]) begin
                        d.high_sw = i_avs_writedata[`PFR_SW_EN_BIT]; // RL6
                     end
                  end
                  PFR_SEL_STAT, PFR_SEL_NONE: begin
                     d.high_sw = q.high_sw;
                  end
               endcase
            end
         end
         default: begin
            d.bus = PFR_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q.bus <= PFR_IDLE;
         q.rdata <= `PFR_RDATA_RST;
         q.resp <= `PFR_RESP_OK;
         q.pof_en <= `PFR_POF_EN_RST; // RL4
         q.main_thr <= `PFR_THR_RST;
         q.high_thr <= `PFR_THR_RST;
         q.main_sw <= `PFR_SW_EN_RST; // RL6
         q.radio_sw <= `PFR_SW_EN_RST;
         q.high_sw <= `PFR_SW_EN_RST;
      end else begin
         q <= d;
      end
   end

   // Every access sees exactly one wait state
   assign o_avs_waitrequest = req && (q.bus != PFR_ACK);
   assign o_avs_readdata = q.rdata;
   assign o_avs_response = q.resp;
   assign o_pof_enable = q.pof_en;
   assign o_main_sw_en = q.main_sw;
   assign o_radio_sw_en = q.radio_sw;
   assign o_high_sw_en = q.high_sw;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   logic wr_pof;
   logic wr_main;
   assign wr_pof = ack && i_avs_write && (sel == PFR_SEL_POF);
   assign wr_main = ack && i_avs_write && (sel == PFR_SEL_MAIN);
   logic wr_radio;
   logic wr_high;
   assign wr_radio = ack && i_avs_write && (sel == PFR_SEL_RADIO);
   assign wr_high = ack && i_avs_write && (sel == PFR_SEL_HIGH);

   wait_bound_a: assert property (req |-> ##[0:1] !o_avs_waitrequest)
      else $error("access not acknowledged within one wait state");

   first_wait_a: assert property (
      (req && q.bus == PFR_IDLE) |-> o_avs_waitrequest)
      else $error("new access acknowledged without a wait state");

   pof_write_a: assert property ( // RL1
      (wr_pof && i_avs_byteenable[0]) |=>
         o_pof_enable == $past(i_avs_writedata[0]))
      else $error("comparator enable does not follow the write");

   main_thr_write_a: assert property ( // RL2
      (wr_pof && i_avs_byteenable[0]) |=>
         q.main_thr == $past(i_avs_writedata[4:1]))
      else $error("main threshold does not follow the write");

   high_thr_write_a: assert property ( // RL3
      (wr_pof && i_avs_byteenable[1]) |=>
         q.high_thr == $past(i_avs_writedata[11:8]))
      else $error("high-supply threshold does not follow the write");

   pof_read_a: assert property ( // RL4
      (i_avs_read && q.bus == PFR_IDLE && sel == PFR_SEL_POF) |=>
         (o_avs_readdata[31:12] == 20'h0 && o_avs_readdata[7:5] == 3'h0
          && o_avs_readdata[0] == o_pof_enable
          && o_avs_readdata[11:8] == q.high_thr))
      else $error("power-fail config readback wrong");

   sw_indep_a: assert property ( // RL6
      wr_main |=> ($stable(o_radio_sw_en) && $stable(o_high_sw_en)))
      else $error("main switching write disturbed another regulator");

   sw_rise_a: assert property ( // RL5
      $rose(o_main_sw_en) |-> $past(wr_main))
      else $error("main switching enabled without a write");

   mode_pick_a: assert property ( // RL7
      ##1 o_pof_threshold == ($past(mode_s) ? $past(q.high_thr)
                                            : $past(q.main_thr)))
      else $error("threshold not taken from the active supply table");

   rsvd_keep_a: assert property ( // RL8
      (wr_pof && i_avs_byteenable[0] && i_avs_writedata[4:1] == 4'h3)
         |=> ##1 (q.main_thr == 4'h3 && (mode_s || thr_rsvd)))
      else $error("reserved main code not stored or not flagged");

   unmapped_a: assert property (
      (ack && sel == PFR_SEL_NONE) |->
         (o_avs_response == 2'h3 && o_avs_readdata == 32'h0))
      else $error("unmapped access not answered with decode error");

   main_sw_write_a: assert property ( // RL5
      (wr_main && i_avs_byteenable[0]) |=>
         o_main_sw_en == $past(i_avs_writedata[0]))
      else $error("main switching enable does not follow the write");

   radio_sw_write_a: assert property ( // RL5
      (wr_radio && i_avs_byteenable[0]) |=>
         o_radio_sw_en == $past(i_avs_writedata[0]))
      else $error("radio switching enable does not follow the write");

   high_sw_write_a: assert property ( // RL5
      (wr_high && i_avs_byteenable[0]) |=>
         o_high_sw_en == $past(i_avs_writedata[0]))
      else $error("high switching enable does not follow the write");

   radio_indep_a: assert property ( // RL6
      wr_radio |=> ($stable(o_main_sw_en) && $stable(o_high_sw_en)))
      else $error("radio switching write disturbed another regulator");

   high_indep_a: assert property ( // RL6
      wr_high |=> ($stable(o_main_sw_en) && $stable(o_radio_sw_en)))
      else $error("high switching write disturbed another regulator");

   thr_valid_a: assert property ( // RL8
      ##1 o_pof_thr_valid == ($past(q.pof_en)
         && ($past(mode_s) || $past(q.main_thr) >= `PFR_MAIN_THR_MIN)))
      else $error("threshold valid flag disagrees with enable and code");

   stat_ro_a: assert property (
      (ack && i_avs_write && sel == PFR_SEL_STAT) |=>
         ($stable(o_pof_enable) && $stable(o_main_sw_en)
          && $stable(o_radio_sw_en) && $stable(o_high_sw_en)))
      else $error("status write changed the configuration");

   rdata_hold_a: assert property (
      !(req && q.bus == PFR_IDLE) |=> $stable(o_avs_readdata))
      else $error("read data changed outside a new access");

   pof_write_c: cover property (wr_pof && i_avs_writedata[0]);
   stat_read_c: cover property (
      ack && i_avs_read && sel == PFR_SEL_STAT);
   unmapped_c: cover property (ack && sel == PFR_SEL_NONE);
   high_mode_c: cover property (o_pof_high_table && o_pof_thr_valid);
   sw_write_c: cover property (wr_high && i_avs_writedata[0]);

endmodule : pfr_regs

// ### rtl/pfr_cfg.svh
// Offsets, field positions, reset values and codes of the power-fail
// and regulator configuration bank.
// Assumes a 12-bit Avalon-MM byte address inside the regulator space.
//
// Operation
// RL1: Comparator enable bit is read-write; 1 switches it on, 0 off.
// RL2: Four-bit main threshold; codes 6..15 give 1.9 V to 2.8 V.
// RL3: Four-bit high-supply threshold; codes 0..15 give 2.7 V to 4.2 V.
// RL4: Config register at 0x510 is retained; all fields zero after reset.
// RL5: Separate switching enable registers at 0x704, 0x904 and 0xB00.
// RL6: Regulators start linear; each switching enable is independent.
// RL7: High-supply threshold applies in high voltage mode, main otherwise.
// RL8: Main codes 0..5 are reserved; stored as written, no threshold.
`ifndef PFR_CFG_SVH
`define PFR_CFG_SVH

`define PFR_ADDR_W 12
`define PFR_OFS_POF_CFG 12'h510
`define PFR_OFS_MAIN_SW 12'h704
`define PFR_OFS_RADIO_SW 12'h904
`define PFR_OFS_HIGH_SW 12'hB00
`define PFR_OFS_STATUS 12'h600

`define PFR_POF_EN_BIT 0
`define PFR_MAIN_THR_LSB 1
`define PFR_MAIN_THR_MSB 4
`define PFR_HIGH_THR_LSB 8
`define PFR_HIGH_THR_MSB 11
`define PFR_SW_EN_BIT 0

`define PFR_ST_MODE_BIT 0
`define PFR_ST_RSVD_BIT 1
`define PFR_ST_THR_LSB 4
`define PFR_ST_THR_MSB 7

`define PFR_POF_EN_RST 1'h0
`define PFR_THR_RST 4'h0
`define PFR_SW_EN_RST 1'h0
`define PFR_RDATA_RST 32'h0

`define PFR_MAIN_THR_MIN 4'h6
`define PFR_RESP_OK 2'h0
`define PFR_RESP_DECERR 2'h3

`endif

// ### rtl/pfr_pkg.sv
// Types shared by the power-fail and regulator configuration bank.
// Assumes pfr_cfg.svh is included by the files that need the numbers.
package pfr_pkg;

   typedef enum logic [1:0] {
      PFR_IDLE = 2'b00,
      PFR_ACK = 2'b01
   } pfr_bus_e;

   typedef enum logic [2:0] {
      PFR_SEL_NONE = 3'h0,
      PFR_SEL_POF = 3'h1,
      PFR_SEL_MAIN = 3'h2,
      PFR_SEL_RADIO = 3'h3,
      PFR_SEL_HIGH = 3'h4,
      PFR_SEL_STAT = 3'h5
   } pfr_sel_e;

   typedef logic [3:0] pfr_thr_t;

   typedef struct packed {
      pfr_bus_e bus;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic pof_en;
      pfr_thr_t main_thr;
      pfr_thr_t high_thr;
      logic main_sw;
      logic radio_sw;
      logic high_sw;
   } pfr_regs_s;

   typedef struct packed {
      logic meta;
      logic sync;
   } pfr_sync_s;

   typedef struct packed {
      pfr_thr_t thr;
      logic high_tab;
      logic valid;
      logic rsvd;
   } pfr_sel_s;

endpackage : pfr_pkg

// ### rtl/pfr_sync.sv
// Two-flop synchroniser for the supply mode level from the pin.
// Assumes the pin is a slow level with no relation to i_sys_clk.
module pfr_sync
   import pfr_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_level,
   output logic o_level
);

   pfr_sync_s q;
   pfr_sync_s d;

   always_comb begin
      d.meta = i_level;
      d.sync = q.meta;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_level = q.sync;

endmodule : pfr_sync

// ### rtl/pfr_thr_sel.sv
// Picks the comparator threshold that applies in the present supply mode.
// Assumes the mode input is already synchronised to i_sys_clk.
`include "pfr_cfg.svh"
module pfr_thr_sel
   import pfr_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_high_mode,
   input wire logic i_pof_en,
   input wire pfr_thr_t i_main_thr,
   input wire pfr_thr_t i_high_thr,
   output pfr_thr_t o_thr,
   output logic o_high_tab,
   output logic o_valid,
   output logic o_rsvd
);

   pfr_sel_s q;
   pfr_sel_s d;

   always_comb begin
      d.high_tab = i_high_mode;
      d.thr = i_high_mode ? i_high_thr : i_main_thr; // RL7
      // Low main codes name no level, so in main mode the comparator gets no valid code
      d.rsvd = !i_high_mode && (i_main_thr < `PFR_MAIN_THR_MIN); // RL8
      d.valid = i_pof_en && !d.rsvd;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_thr = q.thr;
   assign o_high_tab = q.high_tab;
   assign o_valid = q.valid;
   assign o_rsvd = q.rsvd;

endmodule : pfr_thr_sel

// ### tb/pfr_regs_tb_top.sv
// Self-checking bench for the power-fail and regulator configuration bank.
// Assumes pfr_regs with a one-wait-state Avalon-MM slave and one clock.
`include "pfr_cfg.svh"
module pfr_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MAX_CYC = 5000;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [11:0] i_avs_address = 12'h000;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [3:0] i_avs_byteenable = 4'hF;
   logic i_high_volt_mode = 1'b0;
   logic [31:0] o_avs_readdata;
   logic [1:0] o_avs_response;
   logic o_avs_waitrequest;
   logic o_pof_enable;
   logic [3:0] o_pof_threshold;
   logic o_pof_high_table;
   logic o_pof_thr_valid;
   logic o_main_sw_en;
   logic o_radio_sw_en;
   logic o_high_sw_en;
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic [1:0] rsp;
   logic [3:0] code;
   logic [11:0] sw_ofs [3];

   always #5 i_sys_clk = ~i_sys_clk;

   pfr_regs i_pfr_regs (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata),
      .o_avs_response(o_avs_response),
      .o_avs_waitrequest(o_avs_waitrequest),
      .i_high_volt_mode(i_high_volt_mode),
      .o_pof_enable(o_pof_enable),
      .o_pof_threshold(o_pof_threshold),
      .o_pof_high_table(o_pof_high_table),
      .o_pof_thr_valid(o_pof_thr_valid),
      .o_main_sw_en(o_main_sw_en),
      .o_radio_sw_en(o_radio_sw_en),
      .o_high_sw_en(o_high_sw_en)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      if (n_fail == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == MAX_CYC) begin
         n_fail++;
         end_of_test();
      end
   end

   // Waits for the rising edge that sees waitrequest low and takes the answer
   task automatic wait_ack;
      do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata;
      rsp = o_avs_response;
   endtask : wait_ack

   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d,
                         input logic [3:0] be);
      @(posedge i_sys_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_byteenable <= be;
      i_avs_write <= 1'b1;
      wait_ack();
      i_avs_write <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [11:0] a, input logic [31:0] exp,
                         input logic [1:0] exp_rsp);
      @(posedge i_sys_clk);
      i_avs_address <= a;
      i_avs_read <= 1'b1;
      wait_ack();
      i_avs_read <= 1'b0;
      check(rd, exp);
      check({30'h0, rsp}, {30'h0, exp_rsp});
   endtask : bus_rd

   // Lets a register change reach the registered threshold outputs
   task automatic settle;
      repeat (2) @(negedge i_sys_clk);
   endtask : settle

   task automatic set_mode(input logic v);
      @(posedge i_sys_clk);
      i_high_volt_mode <= v;
      repeat (4) @(posedge i_sys_clk);
   endtask : set_mode

   task automatic all_clear;
      bus_rd(`PFR_OFS_POF_CFG, 32'h0, 2'h0);
      for (int i = 0; i < 3; i++) begin
         bus_rd(sw_ofs[i], 32'h0, 2'h0);
      end
      settle();
      check({29'h0, o_main_sw_en, o_radio_sw_en, o_high_sw_en}, 32'h0);
      check({31'h0, o_pof_enable}, 32'h0);
   endtask : all_clear

   initial begin
      sw_ofs = '{`PFR_OFS_MAIN_SW, `PFR_OFS_RADIO_SW, `PFR_OFS_HIGH_SW};
      repeat (4) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      all_clear();
      // Unused bits read zero; lane 0 alone leaves the high field alone
      bus_wr(`PFR_OFS_POF_CFG, 32'hFFFF_FFFF, 4'hF);
      bus_rd(`PFR_OFS_POF_CFG, 32'h0000_0F1F, 2'h0);
      settle();
      check({31'h0, o_pof_enable}, 32'h1);
      check({28'h0, o_pof_threshold}, 32'hF);
      bus_wr(`PFR_OFS_POF_CFG, 32'h0, 4'h1);
      bus_rd(`PFR_OFS_POF_CFG, 32'h0000_0F00, 2'h0);
      settle();
      check({31'h0, o_pof_enable}, 32'h0);
      check({31'h0, o_pof_thr_valid}, 32'h0);
      for (int c = 0; c < 16; c++) begin
         code = c[3:0];
         bus_wr(`PFR_OFS_POF_CFG, {20'h0, 4'hA, 3'h0, code, 1'b1}, 4'hF);
         bus_rd(`PFR_OFS_POF_CFG, {20'h0, 4'hA, 3'h0, code, 1'b1}, 2'h0);
         settle();
         check({28'h0, o_pof_threshold}, {28'h0, code});
         check({31'h0, o_pof_high_table}, 32'h0);
         check({31'h0, o_pof_thr_valid}, {31'h0, c >= 6});
         bus_rd(`PFR_OFS_STATUS,
                {24'h0, code, 2'h0, c < 6, 1'b0}, 2'h0);
         check(rd & 32'hF3, {24'h0, code, 2'h0, c < 6, 1'b0});
      end
      set_mode(1'b1);
      for (int c = 0; c < 16; c++) begin
         code = c[3:0];
         bus_wr(`PFR_OFS_POF_CFG, {20'h0, code, 3'h0, 4'h2, 1'b1}, 4'hF);
         bus_rd(`PFR_OFS_POF_CFG, {20'h0, code, 3'h0, 4'h2, 1'b1}, 2'h0);
         settle();
         check({28'h0, o_pof_threshold}, {28'h0, code});
         check({31'h0, o_pof_high_table}, 32'h1);
         check({31'h0, o_pof_thr_valid}, 32'h1);
         bus_rd(`PFR_OFS_STATUS,
                {24'h0, code, 4'h1}, 2'h0);
         check(rd & 32'hF1, {24'h0, code, 4'h1});
      end
      set_mode(1'b0);
      check({28'h0, o_pof_threshold}, 32'h2);
      check({31'h0, o_pof_high_table}, 32'h0);
      check({31'h0, o_pof_thr_valid}, 32'h0);
      // Each switching enable moves only its own regulator
      for (int i = 0; i < 3; i++) begin
         bus_wr(sw_ofs[i], 32'h1, 4'hF);
         settle();
         check({29'h0, o_main_sw_en, o_radio_sw_en, o_high_sw_en},
               {29'h0, 3'b100 >> i});
         for (int j = 0; j < 3; j++) begin
            bus_rd(sw_ofs[j], {31'h0, i == j}, 2'h0);
         end
         bus_wr(sw_ofs[i], 32'h0, 4'hF);
      end
      // Unmapped and read-only places leave the configuration alone
      bus_wr(12'h514, 32'hFFFF_FFFF, 4'hF);
      bus_rd(12'h514, 32'h0, 2'h3);
      bus_wr(`PFR_OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
      bus_rd(`PFR_OFS_POF_CFG, 32'h0000_0F05, 2'h0);
      // Reset in mid-run clears every field again
      bus_wr(`PFR_OFS_MAIN_SW, 32'h1, 4'hF);
      @(posedge i_sys_clk);
      i_rst_n <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      all_clear();
      end_of_test();
   end
endmodule : pfr_regs_tb_top
